// [hw/ddrp_pkg.sv]
/*
 * Shared constants for the memory pin interface: pin widths, burst length,
 * command encodings, pin patterns and the sequencer state type.
 * Assumes it is compiled before every other file of the block.
 */
package ddrp_pkg;

    // Pin widths
    localparam int DDRP_BANK_W = 3;
    localparam int DDRP_ADDR_W = 14;
    localparam int DDRP_DQ_W = 16;
    localparam int DDRP_LANES = 2;

    // Write and read bursts, in data beats (one beat per system clock on writes, one per strobe edge on reads)
    localparam int DDRP_BURST = 4;

    // Read gives up after this many cycles without a full burst
    localparam int DDRP_RD_TIMEOUT = 64;

    // Synchroniser depth for pin inputs
    localparam int DDRP_SYNC_STAGES = 2;

    // Field positions in the 3-bit row/column/write pin pattern
    localparam int DDRP_PIN_ROW = 2;
    localparam int DDRP_PIN_COL = 1;
    localparam int DDRP_PIN_WE = 0;

    // Reset values of the pins
    localparam logic [2:0] DDRP_PINS_IDLE = 3'h7;
    localparam logic DDRP_SEL_IDLE = 1'b1;

    // User command codes
    typedef enum logic [2:0] {
        DDRP_NOP = 3'b000,
        DDRP_ACTIVATE = 3'b001,
        DDRP_READ = 3'b010,
        DDRP_WRITE = 3'b011,
        DDRP_PRECHARGE = 3'b100,
        DDRP_REFRESH = 3'b101,
        DDRP_LOAD_MODE = 3'b110
    } ddrp_cmd_t;

    // Sequencer states
    typedef enum logic [1:0] {
        DDRP_ST_IDLE = 2'b00,
        DDRP_ST_WRITE = 2'b01,
        DDRP_ST_READ = 2'b10
    } ddrp_state_t;

    // Row strobe, column strobe, write enable (all active low) per command
    function automatic logic [2:0] ddrp_cmd_pins(input ddrp_cmd_t code);
        logic [2:0] pins;
        pins = DDRP_PINS_IDLE;
        unique case (code)
            DDRP_ACTIVATE: pins = 3'h3;
            DDRP_READ: pins = 3'h5;
            DDRP_WRITE: pins = 3'h4;
            DDRP_PRECHARGE: pins = 3'h2;
            DDRP_REFRESH: pins = 3'h1;
            DDRP_LOAD_MODE: pins = 3'h0;
            default: pins = DDRP_PINS_IDLE;
        endcase
        return pins;
    endfunction

endpackage

// [hw/ddrp_sync.sv]
/*
 * Two-stage synchroniser for a bundle of pin inputs.
 * Assumes the inputs are asynchronous to sys_clk; only the last stage
 * may be read by other logic.
 */
`timescale 1ns/1ps
module ddrp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // First stage, read only by the second
    logic [WIDTH-1:0] meta;

    // Two flops in series
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// [hw/ddrp_clk_gen.sv]
/*
 * Memory clock divider: the memory clock and its complement are made
 * from the controller clock by halving it.
 * Assumes sys_clk is the memory controller clock.
 */
`timescale 1ns/1ps
module ddrp_clk_gen (
    input wire logic sys_clk,
    input wire logic arst_n,
    output logic clk_true,
    output logic clk_comp
);

    // Toggle every edge; both outputs are flops so pins stay glitch free.
    // True phase rests high in reset, so the pin copy, which rests low,
    // already toggles at the first edge after release.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_true <= 1'b1;
            clk_comp <= 1'b0;
        end else begin
            clk_true <= ~clk_true;
            clk_comp <= clk_true;
        end
    end

endmodule

// [hw/ddrp_pin_if.sv]
/*
 * Pin-level side of the external dynamic memory interface: command,
 * bank, address, clock, clock enable, chip select, masks, strobes,
 * termination and memory reset, with a 16-bit two-way data bus.
 * Assumes a user that holds cmd_valid until taken, and configuration
 * levels that come from logic on sys_clk.
 */
`timescale 1ns/1ps
module ddrp_pin_if
    import ddrp_pkg::*;
#(
    parameter int BURST = DDRP_BURST,
    parameter int RD_TIMEOUT = DDRP_RD_TIMEOUT
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    // User command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_code,
    input wire logic [DDRP_BANK_W-1:0] cmd_bank,
    input wire logic [DDRP_ADDR_W-1:0] cmd_addr,
    input wire logic [DDRP_DQ_W*BURST-1:0] wr_data,
    input wire logic [DDRP_LANES*BURST-1:0] wr_mask,
    output logic [DDRP_DQ_W-1:0] rd_data,
    output logic rd_valid,
    output logic rd_timeout,
    // Configuration levels
    input wire logic cfg_diff_strobe,
    input wire logic cfg_is_ddr3,
    input wire logic cfg_term_on,
    input wire logic cfg_clk_enable,
    input wire logic cfg_mem_reset,
    // Memory pins
    output logic mem_clk_out,
    output logic mem_clk_out_n,
    output logic mem_clk_enable,
    output logic mem_chip_sel_n,
    output logic mem_row_strobe_n,
    output logic mem_col_strobe_n,
    output logic mem_write_en_n,
    output logic [DDRP_BANK_W-1:0] mem_bank_addr,
    output logic [DDRP_ADDR_W-1:0] mem_addr_bus,
    output logic mem_term_enable,
    output logic mem_reset_out_n,
    output logic mem_reset_oe,
    output logic mem_low_byte_mask,
    output logic mem_high_byte_mask,
    input wire logic [DDRP_DQ_W-1:0] mem_data_bus_i,
    output logic [DDRP_DQ_W-1:0] mem_data_bus_o,
    output logic mem_data_bus_oe,
    input wire logic [DDRP_LANES-1:0] mem_byte_strobe_i,
    output logic [DDRP_LANES-1:0] mem_byte_strobe_o,
    output logic mem_byte_strobe_oe,
    input wire logic [DDRP_LANES-1:0] mem_byte_strobe_n_i,
    output logic [DDRP_LANES-1:0] mem_byte_strobe_n_o,
    output logic mem_byte_strobe_n_oe
);

    localparam int BEAT_W = (BURST > 1) ? $clog2(BURST) : 1;
    localparam int TMO_W = $clog2(RD_TIMEOUT + 1);
    localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST - 1);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(RD_TIMEOUT - 1);

    ddrp_state_t state; // Sequencer state
    ddrp_state_t next_state; // Its next value
    logic [BEAT_W-1:0] beat; // Beat of the current burst
    logic [TMO_W-1:0] tmo; // Cycles spent waiting for read beats
    logic [DDRP_DQ_W*BURST-1:0] wbuf; // Write beats, low beat first
    logic [DDRP_LANES*BURST-1:0] mbuf; // Mask beats, low beat first
    logic clk_true; // Divided clock, true phase
    logic clk_comp; // Divided clock, complement phase
    logic [DDRP_DQ_W-1:0] dq_sync; // Read data after synchroniser
    logic [DDRP_LANES-1:0] dqs_sync; // Read strobes after synchroniser
    logic [DDRP_LANES-1:0] dqs_prev; // Synced strobes one cycle older

    // Command is taken only on a ready cycle
    wire accept = cmd_valid && cmd_ready;
    wire ddrp_cmd_t code_in = ddrp_cmd_t'(cmd_code);
    wire [2:0] pins_in = ddrp_cmd_pins(code_in);
    // Launch edge: memory clock rises here as the pins change; they hold until its next rise
    wire launch = clk_true;
    // A read beat is marked by any edge of the low lane strobe
    wire rd_edge = (state == DDRP_ST_READ) && (dqs_sync[0] != dqs_prev[0]);
    wire wr_last = (state == DDRP_ST_WRITE) && (beat == LAST_BEAT);
    wire rd_last = rd_edge && (beat == LAST_BEAT);
    wire rd_expire = (state == DDRP_ST_READ) && (tmo == TMO_LAST);

    // Memory clock pair from the controller clock
    ddrp_clk_gen u_clk (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clk_true(clk_true),
        .clk_comp(clk_comp)
    );

    // Read data and strobes come from the pins, so synchronise them
    ddrp_sync #(.WIDTH(DDRP_DQ_W + DDRP_LANES)) u_rd_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .din({mem_byte_strobe_i, mem_data_bus_i}),
        .dout({dqs_sync, dq_sync})
    );

    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            DDRP_ST_IDLE: begin
                if (accept && code_in == DDRP_WRITE) begin
                    next_state = DDRP_ST_WRITE;
                end else if (accept && code_in == DDRP_READ) begin
                    next_state = DDRP_ST_READ;
                end
            end
            DDRP_ST_WRITE: begin
                if (wr_last) begin
                    next_state = DDRP_ST_IDLE;
                end
            end
            DDRP_ST_READ: begin
                if (rd_last || rd_expire) begin
                    next_state = DDRP_ST_IDLE;
                end
            end
            default: next_state = DDRP_ST_IDLE;
        endcase
    end

    // State, beat counter and ready; ready only on launch-eve cycles
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= DDRP_ST_IDLE;
            beat <= '0;
            tmo <= '0;
            cmd_ready <= 1'b0;
        end else begin
            state <= next_state;
            cmd_ready <= (next_state == DDRP_ST_IDLE) && !clk_true;
            if (state == DDRP_ST_IDLE || wr_last || rd_last) begin
                beat <= '0;
            end else if (state == DDRP_ST_WRITE || rd_edge) begin
                beat <= beat + 1'b1;
            end
            tmo <= (state == DDRP_ST_READ) ? tmo + 1'b1 : '0;
        end
    end

    // Command pins change only at launch; idle means deselected
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_chip_sel_n <= DDRP_SEL_IDLE;
            mem_row_strobe_n <= DDRP_PINS_IDLE[DDRP_PIN_ROW];
            mem_col_strobe_n <= DDRP_PINS_IDLE[DDRP_PIN_COL];
            mem_write_en_n <= DDRP_PINS_IDLE[DDRP_PIN_WE];
            mem_bank_addr <= '0;
            mem_addr_bus <= '0;
        end else if (launch) begin
            // Pattern encodes the operation
            mem_row_strobe_n <= accept ? pins_in[DDRP_PIN_ROW] : 1'b1;
            mem_col_strobe_n <= accept ? pins_in[DDRP_PIN_COL] : 1'b1;
            mem_write_en_n <= accept ? pins_in[DDRP_PIN_WE] : 1'b1;
            // Select only for a real command
            mem_chip_sel_n <= !(accept && code_in != DDRP_NOP);
            // Bank or mode register index
            if (accept) begin
                mem_bank_addr <= cmd_bank;
                mem_addr_bus <= cmd_addr;
            end
        end
    end

    // Write burst: data, masks and strobes leave together
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wbuf <= '0;
            mbuf <= '0;
            mem_data_bus_o <= '0;
            mem_low_byte_mask <= 1'b0;
            mem_high_byte_mask <= 1'b0;
            mem_byte_strobe_o <= '0;
            mem_byte_strobe_n_o <= '0;
        end else begin
            if (accept && code_in == DDRP_WRITE) begin
                wbuf <= wr_data;
                mbuf <= wr_mask;
            end else if (state == DDRP_ST_WRITE) begin
                wbuf <= wbuf >> DDRP_DQ_W;
                mbuf <= mbuf >> DDRP_LANES;
            end
            mem_data_bus_o <= wbuf[DDRP_DQ_W-1:0];
            // Lane 0 mask covers the low byte, lane 1 the high byte
            mem_low_byte_mask <= mbuf[0];
            mem_high_byte_mask <= mbuf[1];
            // Strobe toggles each beat, so both edges carry a beat
            mem_byte_strobe_o <= {DDRP_LANES{beat[0]}};
            // Complement idles low unless differential
            mem_byte_strobe_n_o <= cfg_diff_strobe ?
                {DDRP_LANES{~beat[0]}} : '0;
        end
    end

    // Drive enables: only during write beats
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_data_bus_oe <= 1'b0;
            mem_byte_strobe_oe <= 1'b0;
            mem_byte_strobe_n_oe <= 1'b0;
        end else begin
            mem_data_bus_oe <= (state == DDRP_ST_WRITE);
            mem_byte_strobe_oe <= (state == DDRP_ST_WRITE);
            // Complement left floating in single-ended mode
            mem_byte_strobe_n_oe <= (state == DDRP_ST_WRITE) &&
                cfg_diff_strobe;
        end
    end

    // Read capture on each synced edge of the low lane strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dqs_prev <= '0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            rd_timeout <= 1'b0;
        end else begin
            dqs_prev <= dqs_sync;
            rd_valid <= rd_edge;
            rd_timeout <= rd_expire && !rd_last;
            if (rd_edge) begin
                rd_data <= dq_sync;
            end
        end
    end

    // Static pins: clock pair, clock enable, termination, memory reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_clk_out <= 1'b0;
            mem_clk_out_n <= 1'b1;
            mem_clk_enable <= 1'b0;
            mem_term_enable <= 1'b0;
            mem_reset_out_n <= 1'b0;
            mem_reset_oe <= 1'b0;
        end else begin
            mem_clk_out <= clk_true;
            mem_clk_out_n <= clk_comp;
            mem_clk_enable <= cfg_clk_enable; // High enables
            // Follows its setting alone, whatever the commands
            mem_term_enable <= cfg_term_on;
            // Reset pin driven only for DDR3 parts
            mem_reset_out_n <= !cfg_mem_reset;
            mem_reset_oe <= cfg_is_ddr3;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_sel_cmd;
        {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} != 3'h7
            |-> !mem_chip_sel_n;
    endproperty
    a_sel_cmd: assert property (p_sel_cmd)
        else $error("command pattern without chip select");

    property p_cmd_hold;
        $fell(mem_chip_sel_n) |=> $stable({mem_row_strobe_n,
            mem_col_strobe_n, mem_write_en_n, mem_bank_addr});
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command pins not held for a memory clock");

    property p_bank;
        accept && code_in != DDRP_NOP |=> mem_bank_addr == $past(cmd_bank)
            && !mem_chip_sel_n;
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank pins do not follow the command");

    property p_load_mode;
        accept && code_in == DDRP_LOAD_MODE |=> !mem_row_strobe_n &&
            !mem_col_strobe_n && !mem_write_en_n &&
            mem_bank_addr == $past(cmd_bank);
    endproperty
    a_load_mode: assert property (p_load_mode)
        else $error("load mode pattern or register index wrong");

    property p_cke;
        ##1 mem_clk_enable == $past(cfg_clk_enable);
    endproperty
    a_cke: assert property (p_cke)
        else $error("clock enable does not follow its setting");

    property p_mask;
        accept && code_in == DDRP_WRITE |=> ##1
            mem_low_byte_mask == $past(wr_mask[0], 2) &&
            mem_high_byte_mask == $past(wr_mask[1], 2) &&
            mem_data_bus_o == $past(wr_data[DDRP_DQ_W-1:0], 2) &&
            mem_data_bus_oe;
    endproperty
    a_mask: assert property (p_mask)
        else $error("first write beat or its masks wrong");

    property p_strobe_dir;
        mem_byte_strobe_oe == mem_data_bus_oe;
    endproperty
    a_strobe_dir: assert property (p_strobe_dir)
        else $error("strobe direction differs from data direction");

    property p_single_ended;
        ##1 !$past(cfg_diff_strobe) |-> !mem_byte_strobe_n_oe;
    endproperty
    a_single_ended: assert property (p_single_ended)
        else $error("complement strobe driven while single-ended");

    property p_term;
        ##1 mem_term_enable == $past(cfg_term_on);
    endproperty
    a_term: assert property (p_term)
        else $error("termination does not follow its setting");

    // Guarded by the reset of one cycle ago: the release edge still resets
    property p_clk_pair;
        $past(arst_n) |-> mem_clk_out_n != mem_clk_out ##1
            mem_clk_out != $past(mem_clk_out);
    endproperty
    a_clk_pair: assert property (p_clk_pair)
        else $error("memory clock pair not complementary or stalled");

    property p_read_release;
        state == DDRP_ST_READ |=> !mem_data_bus_oe;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("data bus driven during a read");

endmodule

// [testbench/ddrp_mem_model.sv]
/*
 * Behavioural external memory for the pin interface bench: stores write
 * bursts with lane masks and answers reads with data and strobe edges.
 * Assumes commands stand two cycles and one beat per sys_clk on writes.
 */
`timescale 1ns/1ps
module ddrp_mem_model
    import ddrp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic cs_n,
    input wire logic [2:0] pins,
    input wire logic [DDRP_BANK_W-1:0] bank,
    input wire logic [DDRP_ADDR_W-1:0] addr,
    input wire logic [DDRP_DQ_W-1:0] dq,
    input wire logic dq_oe,
    input wire logic [1:0] dm,
    input wire logic mute,
    output logic [DDRP_DQ_W-1:0] p_dq,
    output logic p_dqs
);
    // Unwritten lines read back as this pattern
    localparam logic [63:0] FILL = 64'hA5A6_A5A7_A5A4_A5A5;
    logic [63:0] mem [logic [16:0]]; // Lines keyed by bank and address
    logic [63:0] line;
    logic [63:0] rline;
    logic [16:0] wkey;
    int wbeat = 4;

    // Write capture; beats win over the still-standing command pins
    always @(posedge sys_clk) begin
        if (dq_oe && wbeat < 4) begin
            line = mem.exists(wkey) ? mem[wkey] : FILL;
            for (int l = 0; l < 2; l++) begin
                // A high mask keeps the stored lane
                if (!dm[l]) line[wbeat*16+l*8+:8] = dq[l*8+:8];
            end
            mem[wkey] = line;
            wbeat++;
        end else if (!cs_n && pins == 3'b100) begin
            wkey = {bank, addr};
            wbeat = 0;
        end
    end

    // Read answer: data changes with each strobe edge, two cycles a beat
    initial begin
        p_dq = '0;
        p_dqs = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (!cs_n && pins == 3'b101 && !mute) begin
                rline = mem.exists({bank, addr}) ? mem[{bank, addr}] : FILL;
                repeat (3) @(posedge sys_clk);
                for (int b = 0; b < 4; b++) begin
                    p_dq <= rline[b*16+:16];
                    p_dqs <= ~p_dqs;
                    repeat (2) @(posedge sys_clk);
                end
                // Released lines have no pull: show the inverse level
                p_dq <= ~p_dq;
                p_dqs <= ~p_dqs;
            end
        end
    end
endmodule

// [testbench/ddr_memory_pin_interface_tb_top.sv]
/*
 * Self-checking bench for the memory pin interface with a memory model.
 * Assumes the design runs with a burst of four beats.
 */
`timescale 1ns/1ps
module ddr_memory_pin_interface_tb_top
    import ddrp_pkg::*;
;
    localparam logic [63:0] FILL = 64'hA5A6_A5A7_A5A4_A5A5;
    logic sys_clk = 0, arst_n = 0, cmd_valid = 0, mute = 0;
    logic [2:0] cmd_code = '0, cmd_bank = '0;
    logic [13:0] cmd_addr = '0;
    logic [63:0] wr_data = '0;
    logic [7:0] wr_mask = '0;
    logic cfg_diff = 0, cfg_ddr3 = 0, cfg_term = 0, cfg_cke = 0, cfg_rst = 0;
    logic cmd_ready, rd_valid, rd_timeout, clk_t, clk_c, cke, cs_n;
    logic ras_n, cas_n, we_n, odt, rst_n, rst_oe, dm_lo, dm_hi;
    logic dq_oe, dqs_oe, dqsn_oe, p_dqs, clk_prev, live;
    logic [2:0] mba;
    logic [13:0] maddr;
    logic [15:0] rd_data, dq_o, dq_i, p_dq;
    logic [1:0] dqs_o, dqs_i, dqsn_o, dqsn_i;
    logic [63:0] bmem [logic [16:0]]; // Expected memory contents
    int n_fail = 0;
    int compares = 0;

    // Pins resolve from whichever party drives them
    assign dq_i = dq_oe ? dq_o : p_dq;
    assign dqs_i = dqs_oe ? dqs_o : {2{p_dqs}};
    assign dqsn_i = dqsn_oe ? dqsn_o : ~{2{p_dqs}};

    ddrp_pin_if #(.BURST(4), .RD_TIMEOUT(64)) DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .wr_data(wr_data), .wr_mask(wr_mask),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_timeout(rd_timeout),
        .cfg_diff_strobe(cfg_diff), .cfg_is_ddr3(cfg_ddr3),
        .cfg_term_on(cfg_term), .cfg_clk_enable(cfg_cke),
        .cfg_mem_reset(cfg_rst), .mem_clk_out(clk_t), .mem_clk_out_n(clk_c),
        .mem_clk_enable(cke), .mem_chip_sel_n(cs_n),
        .mem_row_strobe_n(ras_n), .mem_col_strobe_n(cas_n),
        .mem_write_en_n(we_n), .mem_bank_addr(mba), .mem_addr_bus(maddr),
        .mem_term_enable(odt), .mem_reset_out_n(rst_n),
        .mem_reset_oe(rst_oe), .mem_low_byte_mask(dm_lo),
        .mem_high_byte_mask(dm_hi), .mem_data_bus_i(dq_i),
        .mem_data_bus_o(dq_o), .mem_data_bus_oe(dq_oe),
        .mem_byte_strobe_i(dqs_i), .mem_byte_strobe_o(dqs_o),
        .mem_byte_strobe_oe(dqs_oe), .mem_byte_strobe_n_i(dqsn_i),
        .mem_byte_strobe_n_o(dqsn_o), .mem_byte_strobe_n_oe(dqsn_oe)
    );

    ddrp_mem_model u_mem (
        .sys_clk(sys_clk), .cs_n(cs_n), .pins({ras_n, cas_n, we_n}),
        .bank(mba), .addr(maddr), .dq(dq_o), .dq_oe(dq_oe),
        .dm({dm_hi, dm_lo}), .mute(mute), .p_dq(p_dq), .p_dqs(p_dqs)
    );

    // Compare one value, count it, report a difference at once
    task automatic check(input logic [63:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, seen,
                exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Row, column, write pins (active low) expected for a command code
    function automatic logic [2:0] pins_exp(input logic [2:0] code);
        case (code)
            3'h1: return 3'b011;
            3'h2: return 3'b101;
            3'h3: return 3'b100;
            3'h4: return 3'b010;
            3'h5: return 3'b001;
            3'h6: return 3'b000;
            default: return 3'b111;
        endcase
    endfunction

    // A set mask bit keeps the old byte of that lane and beat
    function automatic logic [63:0] merge(input logic [63:0] old, wd,
        input logic [7:0] wm);
        for (int j = 0; j < 8; j++) begin
            if (!wm[j]) old[j*8+:8] = wd[j*8+:8];
        end
        return old;
    endfunction

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Cut a hang short well past the planned run length
    initial begin
        #300_000;
        n_fail++;
        end_of_test();
    end

    // Memory clock halves sys_clk and its complement tracks it
    always @(posedge sys_clk) live <= arst_n;
    always @(negedge sys_clk) begin
        if (live) begin
            check(clk_c, {~clk_t}, "clock complement");
            check(clk_t, {~clk_prev}, "clock toggle");
        end
        clk_prev = clk_t;
    end

    // Change levels, then look at the pins one edge later
    task automatic set_cfg(input logic [4:0] v);
        @(posedge sys_clk);
        {cfg_diff, cfg_ddr3, cfg_term, cfg_cke, cfg_rst} <= v;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({cke, odt, rst_n, rst_oe}, {v[1], v[2], ~v[0], v[3]},
            "config pins");
    endtask

    // One command through the handshake, with pin, write and read checks
    task automatic issue(input logic [2:0] code, b, input logic [13:0] a,
        input logic [63:0] wd, input logic [7:0] wm);
        int n;
        logic [63:0] exp;
        n = 0;
        exp = bmem.exists({b, a}) ? bmem[{b, a}] : FILL;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        {cmd_code, cmd_bank, cmd_addr, wr_data, wr_mask} <= {code, b, a, wd, wm};
        do begin
            @(posedge sys_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 40);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        check(cs_n, code == 3'h0, "chip select");
        check(odt, cfg_term, "termination");
        if (code != 3'h0) begin
            check({ras_n, cas_n, we_n}, pins_exp(code), "pins");
            check({mba, maddr}, {b, a}, "bank addr");
        end
        if (code == 3'h3) begin
            bmem[{b, a}] = merge(exp, wd, wm);
            for (int i = 0; i < 4; i++) begin
                @(negedge sys_clk);
                check({dq_oe, dqs_oe, dqs_o}, {2'b11, {2{i[0]}}}, "strobe");
                check({dm_hi, dm_lo, dq_o}, {wm[2*i+:2], wd[16*i+:16]}, "beat");
                check(dqsn_oe, cfg_diff, "complement drive");
                if (cfg_diff) check(dqsn_o, {~dqs_o}, "complement");
            end
            @(negedge sys_clk);
            check(dq_oe, 1'b0, "release after write");
        end
        if (code == 3'h2) begin
            n = 0;
            for (int t = 0; t < 80 && n < 4; t++) begin
                @(negedge sys_clk);
                check(dq_oe, 1'b0, "released in read");
                if (rd_timeout === 1'b1) n = 9;
                if (rd_valid === 1'b1) begin
                    check(rd_data, exp[16*n+:16], "read beat");
                    n++;
                end
            end
            check(n, mute ? 9 : 4, "read end");
            repeat (8) @(posedge sys_clk);
        end
    endtask

    initial begin
        void'($urandom(30));
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        check({cs_n, clk_c, dq_oe, dqs_oe, cmd_ready}, 5'b11000, "reset");
        @(posedge sys_clk);
        arst_n <= 1'b1;
        set_cfg(5'b0_0110);
        // Every command code, with bank and address taken from the code; the load uses bank 6
        for (int c = 0; c < 7; c++) begin
            issue(c[2:0], c[2:0], 14'h0040 + 14'(c), {$urandom, $urandom}, 8'h00);
        end
        // Fully masked write leaves the fill pattern, then partial masks
        issue(3'h3, 3'h2, 14'h0100, {$urandom, $urandom}, 8'hFF);
        issue(3'h2, 3'h2, 14'h0100, '0, '0);
        issue(3'h3, 3'h2, 14'h0100, {$urandom, $urandom}, 8'h5A);
        issue(3'h3, 3'h2, 14'h0100, {$urandom, $urandom}, 8'hA5);
        issue(3'h2, 3'h2, 14'h0100, '0, '0);
        // Random traffic over a small key set so reads hit writes
        for (int r = 0; r < 40; r++) begin
            set_cfg(5'($urandom));
            issue(3'($urandom_range(0, 6)), 3'($urandom_range(0, 7)),
                14'($urandom_range(0, 3)), {$urandom, $urandom}, 8'($urandom));
        end
        // Memory stays silent: the read must give up
        mute <= 1'b1;
        issue(3'h2, 3'h1, 14'h0001, '0, '0);
        mute <= 1'b0;
        end_of_test();
    end
endmodule
